// File: tmr_pkg.sv
// Package for the 10-bit standard timer: register map, fields, modes.
// Assumes one 32-bit AXI4-Lite register bus and a single clock.
package tmr_pkg;

   // ************************************************************
   // Register map (byte addresses, one word per register)
   // ************************************************************
   localparam logic [7:0] ctrl0_addr      = 8'h00;
   localparam logic [7:0] ctrl1_addr      = 8'h04;
   localparam logic [7:0] cnt_low_addr    = 8'h08;
   localparam logic [7:0] cnt_high_addr   = 8'h0C;
   localparam logic [7:0] cmp_low_addr    = 8'h10;
   localparam logic [7:0] cmp_high_addr   = 8'h14;
   localparam logic [7:0] flags_addr      = 8'h18;

   localparam logic [7:0] ctrl0_reset     = 8'h00;
   localparam logic [7:0] ctrl1_reset     = 8'h00;
   localparam int         cnt_width       = 10;
   localparam int         coarse_lsb      = 7;
   localparam logic [1:0] axi_okay        = 2'b00;
   localparam logic [1:0] axi_slverr      = 2'b10;

   // ************************************************************
   // Field encodings
   // ************************************************************
   typedef enum logic [1:0] {
      mode_compare = 2'b00,
      mode_capture = 2'b01,
      mode_pwm     = 2'b10,
      mode_timer   = 2'b11
   } op_mode_e;

   typedef enum logic [2:0] {
      clk_sys_div4  = 3'b000,
      clk_sys       = 3'b001,
      clk_high_d16  = 3'b010,
      clk_high_d64  = 3'b011,
      clk_sub_a     = 3'b100,
      clk_sub_b     = 3'b101,
      clk_ext_rise  = 3'b110,
      clk_ext_fall  = 3'b111
   } clk_sel_e;

   localparam logic [1:0] act_none   = 2'b00;
   localparam logic [1:0] act_low    = 2'b01;
   localparam logic [1:0] act_high   = 2'b10;
   localparam logic [1:0] act_toggle = 2'b11;
   localparam logic [1:0] act_single = 2'b11;
   localparam logic [1:0] cap_rise   = 2'b00;
   localparam logic [1:0] cap_fall   = 2'b01;
   localparam logic [1:0] cap_both   = 2'b10;

   localparam logic [5:0] div4_last  = 6'h03;
   localparam logic [5:0] div16_last = 6'h0F;
   localparam logic [5:0] div64_last = 6'h3F;

   typedef struct packed {
      logic     count_hold_ctl;
      clk_sel_e count_clk_sel;
      logic     timer_run_ctl;
      logic [2:0] period_coarse_cmp;
   } ctrl0_s;

   typedef struct packed {
      op_mode_e   op_mode_sel;
      logic [1:0] pin_action_sel;
      logic       output_initial_level;
      logic       out_polarity;
      logic       duty_swap;
      logic       clear_source_sel;
   } ctrl1_s;

endpackage

// File: std_timer.sv
// 10-bit standard timer core with AXI4-Lite register slave.
// Assumes high/sub clock ticks arrive as one-cycle enables on mclk; sys is mclk itself.
//
// Summary of operation
// - Ten-bit counter counts up once per selected timer clock tick.
// - Clock select picks sys/4, sys, high/16, high/64, sub, ext rise, ext fall.
// - Hold bit freezes counter; clearing resumes from retained value.
// - Run bit rising clears counter, then counting begins.
// - Run bit falling stops counting and keeps residual count.
// - Run rising forces pin to initial level in compare mode, its inverse in PWM mode.
// - Coarse value n matches counter bits 9..7, period n*128, zero 1024.
// - Fine compare is ten bits compared with whole counter.
// - Counter clears on overflow or selected match; a match, or overflow with clear source zero, raises request.
// - Software cannot load counter; run rising is its only software clear.
// - Compare low byte write goes only into shared holding buffer.
// - Compare high byte write also copies buffer into low byte.
// - High byte read returns high, captures paired low into buffer.
// - Low byte read returns holding buffer contents.
// - Inverted pin is always the inverse of timer output pin.
// - Compare mode match sets, clears or toggles output pin.
// - Single pulse mode uses external clock pin as trigger.
// - Capture input reacts to rising, falling or both edges.
// - Clear source zero: coarse period match clears counter.
// - Coarse value zero lets counter run to maximum and overflow.
// - Mode field: compare, capture, PWM/single pulse, timer.
// - Clear source one: fine compare match clears counter.
// - Initial level bit sets pre-match level or PWM active level.
`timescale 1ns/100ps
`default_nettype none

module std_timer
   import tmr_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        high_clk_tick,
   input  wire logic        sub_clk_tick,
   input  wire logic        ext_clock_pin,
   input  wire logic        capture_in_pin,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             timer_out_pin,
   output logic             timer_out_inv_pin,
   output logic             match_fine_irq,
   output logic             match_period_irq
);

   // ************************************************************
   // Registers
   // ************************************************************
   ctrl0_s                 ctrl0_q;
   ctrl1_s                 ctrl1_q;
   logic [cnt_width-1:0]   count_q;
   logic [cnt_width-1:0]   cmp_fine_q;
   logic [7:0]             hold_buf_q;
   logic                   flag_fine_q;
   logic                   flag_period_q;
   logic                   flag_cap_q;
   logic [cnt_width-1:0]   capture_q;
   logic                   run_prev_q;
   logic                   ext_prev_q;
   logic                   cap_prev_q;
   logic [5:0]             div_q;
   logic                   out_q;
   logic                   pulse_q;
   logic [7:0]             aw_addr_q;
   logic                   aw_have_q;
   logic [31:0]            w_data_q;
   logic [3:0]             w_strb_q;
   logic                   w_have_q;

   // ************************************************************
   // Timer clock selection
   // ************************************************************
   logic tick;
   logic run_rise;
   logic ext_rise;
   logic ext_fall;
   logic div_hit;
   logic counting;

   assign run_rise = ctrl0_q.timer_run_ctl & ~run_prev_q;
   assign ext_rise = ext_clock_pin & ~ext_prev_q;
   assign ext_fall = ~ext_clock_pin & ext_prev_q;

   // Prescaler runs off mclk (sys) or high_clk_tick and is shared by all taps
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_q <= 6'h00;
      end else if (ctrl0_q.count_clk_sel == clk_sys_div4) begin
         div_q <= div_q + 6'h01;
      end else if (high_clk_tick) begin
         div_q <= div_q + 6'h01;
      end
   end

   always_comb begin
      div_hit = 1'b0;
      case (ctrl0_q.count_clk_sel)
         clk_sys_div4: div_hit = (div_q[1:0] == div4_last[1:0]);
         clk_high_d16: div_hit = high_clk_tick & (div_q[3:0] == div16_last[3:0]);
         clk_high_d64: div_hit = high_clk_tick & (div_q == div64_last);
         default:      div_hit = 1'b0;
      endcase
   end

   always_comb begin
      case (ctrl0_q.count_clk_sel)
         clk_sys_div4, clk_high_d16, clk_high_d64: tick = div_hit;
         clk_sys:                    tick = 1'b1;
         clk_sub_a, clk_sub_b:       tick = sub_clk_tick;
         clk_ext_rise:               tick = ext_rise;
         clk_ext_fall:               tick = ext_fall;
         default:                    tick = 1'b0;
      endcase
   end

   // ************************************************************
   // Counter and comparators
   // ************************************************************
   logic period_match;
   logic fine_match;
   logic overflow;
   logic pwm_mode;
   logic single_mode;

   assign pwm_mode    = (ctrl1_q.op_mode_sel == mode_pwm);
   assign single_mode = pwm_mode & (ctrl1_q.pin_action_sel == act_single);
   // Single pulse waits for the trigger; otherwise run and not held
   assign counting    = ctrl0_q.timer_run_ctl & ~ctrl0_q.count_hold_ctl
                        & (~single_mode | pulse_q) & tick;
   // Coarse zero never matches; clears happen by overflow instead
   assign period_match = counting & (ctrl0_q.period_coarse_cmp != 3'b000)
                         // Last count of block n-1, so the period is n whole blocks
                         & (count_q[cnt_width-1:coarse_lsb]
                            == ctrl0_q.period_coarse_cmp - 3'b001)
                         & (count_q[coarse_lsb-1:0] == '1);
   assign fine_match   = counting & (count_q == cmp_fine_q);
   assign overflow     = counting & (count_q == '1);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         run_prev_q <= 1'b0;
         ext_prev_q <= 1'b0;
         cap_prev_q <= 1'b0;
      end else begin
         run_prev_q <= ctrl0_q.timer_run_ctl;
         ext_prev_q <= ext_clock_pin;
         cap_prev_q <= capture_in_pin;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         count_q <= '0;
      end else if (run_rise) begin
         count_q <= '0;
      end else if (counting) begin
         if ((ctrl1_q.clear_source_sel && fine_match)
             || (!ctrl1_q.clear_source_sel && period_match)) begin
            count_q <= '0;
         end else begin
            count_q <= count_q + 1'b1;
         end
      end
   end

   // Set wins over a same-cycle software clear
   logic       cap_evt;
   logic [2:0] flag_clr;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flag_fine_q   <= 1'b0;
         flag_period_q <= 1'b0;
         flag_cap_q    <= 1'b0;
      end else begin
         flag_fine_q   <= fine_match | cap_evt | (flag_fine_q & ~flag_clr[0]);
         flag_period_q <= (period_match | (overflow & ~ctrl1_q.clear_source_sel))
                          | (flag_period_q & ~flag_clr[1]);
         flag_cap_q    <= cap_evt | (flag_cap_q & ~flag_clr[2]);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         match_fine_irq   <= 1'b0;
         match_period_irq <= 1'b0;
      end else begin
         match_fine_irq   <= flag_fine_q;
         match_period_irq <= flag_period_q;
      end
   end

   // ************************************************************
   // Capture input
   // ************************************************************
   always_comb begin
      cap_evt = 1'b0;
      if (ctrl1_q.op_mode_sel == mode_capture && ctrl0_q.timer_run_ctl) begin
         case (ctrl1_q.pin_action_sel)
            cap_rise: cap_evt = capture_in_pin & ~cap_prev_q;
            cap_fall: cap_evt = ~capture_in_pin & cap_prev_q;
            cap_both: cap_evt = capture_in_pin ^ cap_prev_q;
            default:  cap_evt = 1'b0;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         capture_q <= '0;
      end else if (cap_evt) begin
         capture_q <= count_q;
      end
   end

   // ************************************************************
   // Output pin
   // ************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pulse_q <= 1'b0;
      end else if (run_rise || !ctrl0_q.timer_run_ctl) begin
         pulse_q <= 1'b0;
      end else if (single_mode && ext_rise) begin
         pulse_q <= 1'b1;
      end else if (single_mode && fine_match) begin
         pulse_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         out_q <= 1'b0;
      end else if (run_rise && ctrl1_q.op_mode_sel != mode_timer
                   && ctrl1_q.op_mode_sel != mode_capture) begin
         out_q <= pwm_mode ? ~ctrl1_q.output_initial_level
                           : ctrl1_q.output_initial_level;
      end else if (ctrl1_q.op_mode_sel == mode_compare && fine_match) begin
         case (ctrl1_q.pin_action_sel)
            act_low:    out_q <= 1'b0;
            act_high:   out_q <= 1'b1;
            act_toggle: out_q <= ~out_q;
            default:    out_q <= out_q;
         endcase
      end else if (pwm_mode) begin
         case (ctrl1_q.pin_action_sel)
            act_none:   out_q <= ~ctrl1_q.output_initial_level;
            act_low:    out_q <= ctrl1_q.output_initial_level;
            act_high:   out_q <= ((count_q < cmp_fine_q) ~^ ctrl1_q.output_initial_level);
            default:    out_q <= pulse_q ~^ ctrl1_q.output_initial_level;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         timer_out_pin     <= 1'b0;
         timer_out_inv_pin <= 1'b1;
      end else begin
         timer_out_pin     <= out_q ^ ctrl1_q.out_polarity;
         timer_out_inv_pin <= ~(out_q ^ ctrl1_q.out_polarity);
      end
   end

   // ************************************************************
   // AXI4-Lite slave
   // ************************************************************
   logic wr_go;
   logic rd_go;
   assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
   assign rd_go = s_axi_arvalid & s_axi_arready;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h0000_0000;
         w_strb_q      <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= axi_okay;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q     <= s_axi_awaddr;
            aw_have_q     <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            w_have_q     <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q > flags_addr || aw_addr_q[1:0] != 2'b00
                             || aw_addr_q == cnt_low_addr || aw_addr_q == cnt_high_addr)
                            ? axi_slverr : axi_okay;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   logic wr_lane0;
   assign wr_lane0 = wr_go & w_strb_q[0];
   assign flag_clr = (wr_lane0 && aw_addr_q == flags_addr) ? w_data_q[2:0] : 3'b000;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl0_q    <= ctrl0_reset;
         ctrl1_q    <= ctrl1_reset;
         cmp_fine_q <= '0;
      end else if (wr_lane0) begin
         case (aw_addr_q)
            ctrl0_addr:    ctrl0_q <= w_data_q[7:0];
            ctrl1_addr:    ctrl1_q <= w_data_q[7:0];
            cmp_high_addr: cmp_fine_q <= {w_data_q[1:0], hold_buf_q};
            default:       ctrl0_q <= ctrl0_q;
         endcase
      end
   end

   // Shared low-byte buffer; wrong access order corrupts it by design
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hold_buf_q <= 8'h00;
      end else if (wr_lane0 && aw_addr_q == cmp_low_addr) begin
         hold_buf_q <= w_data_q[7:0];
      end else if (rd_go && s_axi_araddr == cnt_high_addr) begin
         hold_buf_q <= count_q[7:0];
      end else if (rd_go && s_axi_araddr == cmp_high_addr) begin
         hold_buf_q <= cmp_fine_q[7:0];
      end
   end

   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         ctrl0_addr:    rd_word[7:0] = ctrl0_q;
         ctrl1_addr:    rd_word[7:0] = ctrl1_q;
         cnt_low_addr:  rd_word[7:0] = hold_buf_q;
         cnt_high_addr: rd_word[1:0] = count_q[9:8];
         cmp_low_addr:  rd_word[7:0] = hold_buf_q;
         cmp_high_addr: rd_word[1:0] = cmp_fine_q[9:8];
         flags_addr:    rd_word = {6'h00, capture_q, 13'h0000, flag_cap_q,
                                   flag_period_q, flag_fine_q};
         default:       rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= axi_okay;
      end else if (rd_go) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_word;
         s_axi_rresp   <= (s_axi_araddr > flags_addr || s_axi_araddr[1:0] != 2'b00)
                          ? axi_slverr : axi_okay;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   property p_run_clear;
      @(posedge mclk) disable iff (rst) run_rise |=> (count_q == '0);
   endproperty
   a_run_clear: assert property (p_run_clear) else $error("Run rise did not clear");

   property p_hold;
      @(posedge mclk) disable iff (rst)
         (ctrl0_q.count_hold_ctl && !run_rise) |=> (count_q == $past(count_q));
   endproperty
   a_hold: assert property (p_hold) else $error("Counter moved while held");

   property p_inv;
      @(posedge mclk) disable iff (rst) timer_out_inv_pin == ~timer_out_pin;
   endproperty
   a_inv: assert property (p_inv) else $error("Inverted pin mismatch");

   property p_fine_flag;
      @(posedge mclk) disable iff (rst) fine_match |=> flag_fine_q ##1 match_fine_irq;
   endproperty
   a_fine_flag: assert property (p_fine_flag) else $error("Fine flag missing");

   property p_fine_clear;
      @(posedge mclk) disable iff (rst)
         (fine_match && ctrl1_q.clear_source_sel && !run_rise) |=> (count_q == '0);
   endproperty
   a_fine_clear: assert property (p_fine_clear) else $error("Fine match no clear");

   property p_period_clear;
      @(posedge mclk) disable iff (rst)
         (period_match && !ctrl1_q.clear_source_sel && !run_rise) |=> (count_q == '0);
   endproperty
   a_period_clear: assert property (p_period_clear) else $error("Period no clear");

   property p_cmp_write;
      @(posedge mclk) disable iff (rst)
         (wr_lane0 && aw_addr_q == cmp_high_addr)
            |=> (cmp_fine_q[7:0] == $past(hold_buf_q));
   endproperty
   a_cmp_write: assert property (p_cmp_write) else $error("Buffer not copied");

   property p_low_write;
      @(posedge mclk) disable iff (rst)
         (wr_lane0 && aw_addr_q == cmp_low_addr) |=> $stable(cmp_fine_q);
   endproperty
   a_low_write: assert property (p_low_write) else $error("Low write hit register");

   property p_period_point;
      @(posedge mclk) disable iff (rst)
         period_match |-> (count_q + 1'b1 == {ctrl0_q.period_coarse_cmp, {coarse_lsb{1'b0}}});
   endproperty
   a_period_point: assert property (p_period_point) else $error("Period match off end");

endmodule

`default_nettype wire

// File: std_timer_tb.sv
// Self-checking bench for the 10-bit standard timer core.
// Assumes tmr_pkg and std_timer are compiled first; one 50 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module std_timer_tb
   import tmr_pkg::*;
   ;
   logic        mclk, rst, hi_t, sub_t, ext, cap, p;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, last;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, pin, pin_n, irq_f, irq_p;
   logic [31:0] eq[$], mq[$];
   logic [1:0]  rq[$], bq[$];
   logic [9:0]  c1, c2, v;
   int          num_errors = 0;
   int          tests_run = 0;
   int          tog;

   std_timer u_dut (.mclk(mclk), .rst(rst), .high_clk_tick(hi_t), .sub_clk_tick(sub_t),
      .ext_clock_pin(ext), .capture_in_pin(cap), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .timer_out_pin(pin), .timer_out_inv_pin(pin_n),
      .match_fine_irq(irq_f), .match_period_irq(irq_p));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // ************************************************************
   // Bus tasks and checking
   // ************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Handshakes sampled at the negedge before the edge; outputs are registered
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      logic da, dw, sa, sw, sb;
      bq.push_back(r);
      da = 1'b0;
      dw = 1'b0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(da && dw)) begin
         @(negedge mclk);
         sa = awready & ~da;
         sw = wready & ~dw;
         @(posedge mclk);
         if (sa) begin
            awvalid <= 1'b0;
            da = 1'b1;
         end
         if (sw) begin
            wvalid <= 1'b0;
            dw = 1'b1;
         end
      end
      do begin
         @(negedge mclk);
         sb = bvalid;
         @(posedge mclk);
      end while (!sb);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] r);
      logic s;
      eq.push_back(e);
      mq.push_back(m);
      rq.push_back(r);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge mclk);
         s = arready;
         @(posedge mclk);
      end while (!s);
      arvalid <= 1'b0;
      do begin
         @(negedge mclk);
         s = rvalid;
         last = rdata;
         @(posedge mclk);
      end while (!s);
      rready <= 1'b0;
   endtask

   // High byte first so the low read returns the latched buffer
   task automatic rdcnt(output logic [9:0] c);
      logic [7:0] h;
      rd(cnt_high_addr, 32'h0, 32'h0, axi_okay);
      h = last[7:0];
      rd(cnt_low_addr, 32'h0, 32'h0, axi_okay);
      c = {h[1:0], last[7:0]};
   endtask

   task automatic done(input string n);
      $display("test %s finished", n);
   endtask

   always @(posedge mclk) begin
      hi_t <= 1'($urandom);
      sub_t <= 1'($urandom);
      ext <= 1'($urandom);
      if (!rst) begin
         chk({31'h0, pin_n}, {31'h0, ~pin});
         if (rvalid && rready) begin
            chk(rdata & mq[0], eq[0] & mq[0]);
            chk(32'(rresp), 32'(rq[0]));
            void'(eq.pop_front());
            void'(mq.pop_front());
            void'(rq.pop_front());
         end
         if (bvalid && bready) begin
            chk(32'(bresp), 32'(bq.pop_front()));
         end
      end
   end

   initial begin
      repeat (60000) @(posedge mclk);
      num_errors++;
      report_and_stop();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {hi_t, sub_t, ext, cap, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'h1;
      rst = 1'b1;
      void'($urandom(32'hfab1));
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk({30'h0, pin, pin_n}, 32'h1);
      rd(ctrl0_addr, 32'h0, 32'hff, axi_okay);
      rd(ctrl1_addr, 32'h0, 32'hff, axi_okay);
      rd(8'h1C, 32'h0, 32'hffff_ffff, axi_slverr);
      done("reset");
      for (int s = 0; s < 8; s++) begin
         wr(ctrl0_addr, {1'b0, 3'(s), 4'h8}, axi_okay);
         repeat (300) @(posedge mclk);
         wr(ctrl0_addr, {1'b1, 3'(s), 4'h8}, axi_okay);
         rdcnt(c1);
         chk({31'h0, c1 != 10'h0}, 32'h1);
         wr(ctrl0_addr, 8'h00, axi_okay);
      end
      done("clock select");
      wr(ctrl0_addr, 8'h18, axi_okay);
      repeat (30) @(posedge mclk);
      wr(ctrl0_addr, 8'h98, axi_okay);
      rdcnt(c1);
      repeat (20) @(posedge mclk);
      rdcnt(c2);
      chk(32'(c2), 32'(c1));
      wr(cnt_low_addr, 8'h00, axi_slverr);
      rdcnt(c2);
      chk(32'(c2), 32'(c1));
      wr(ctrl0_addr, 8'h18, axi_okay);
      repeat (20) @(posedge mclk);
      wr(ctrl0_addr, 8'h10, axi_okay);
      rdcnt(c2);
      chk({31'h0, c2 > c1}, 32'h1);
      repeat (20) @(posedge mclk);
      rdcnt(c1);
      chk(32'(c1), 32'(c2));
      wr(ctrl0_addr, 8'h98, axi_okay);
      rdcnt(c1);
      chk(32'(c1), 32'h0);
      done("hold and run");
      v = 10'($urandom_range(40, 16));
      wr(cmp_low_addr, 8'hA5, axi_okay);
      rd(cmp_high_addr, 32'h0, 32'h3, axi_okay);
      rd(cmp_low_addr, 32'h0, 32'hff, axi_okay);
      wr(cmp_low_addr, v[7:0], axi_okay);
      wr(cmp_high_addr, {6'h0, v[9:8]}, axi_okay);
      rd(cmp_high_addr, {30'h0, v[9:8]}, 32'h3, axi_okay);
      rd(cmp_low_addr, {24'h0, v[7:0]}, 32'hff, axi_okay);
      done("compare buffer");
      wr(ctrl0_addr, 8'h00, axi_okay);
      wr(flags_addr, 8'h07, axi_okay);
      wr(ctrl1_addr, 8'h19, axi_okay);
      wr(ctrl0_addr, 8'h18, axi_okay);
      repeat (2) @(posedge mclk);
      chk({31'h0, pin}, 32'h1);
      repeat (int'(v) + 20) @(posedge mclk);
      chk({31'h0, pin}, 32'h0);
      rd(flags_addr, 32'h1, 32'h3, axi_okay);
      chk({30'h0, irq_p, irq_f}, 32'h1);
      wr(ctrl0_addr, 8'h10, axi_okay);
      wr(ctrl1_addr, 8'h31, axi_okay);
      wr(ctrl0_addr, 8'h18, axi_okay);
      tog = 0;
      p = pin;
      repeat (10 * (int'(v) + 1) + 5) begin
         @(posedge mclk);
         if (pin !== p) tog++;
         p = pin;
      end
      chk({31'h0, tog >= 9 && tog <= 11}, 32'h1);
      done("compare output");
      wr(ctrl0_addr, 8'h00, axi_okay);
      wr(ctrl1_addr, 8'hC0, axi_okay);
      wr(flags_addr, 8'h07, axi_okay);
      wr(ctrl0_addr, 8'h19, axi_okay);
      repeat (300) @(posedge mclk);
      wr(ctrl0_addr, 8'h99, axi_okay);
      rd(flags_addr, 32'h2, 32'h2, axi_okay);
      rdcnt(c1);
      chk({31'h0, c1 < 10'd128}, 32'h1);
      wr(ctrl0_addr, 8'h00, axi_okay);
      wr(flags_addr, 8'h07, axi_okay);
      wr(ctrl0_addr, 8'h18, axi_okay);
      repeat (1100) @(posedge mclk);
      rd(flags_addr, 32'h2, 32'h2, axi_okay);
      chk({31'h0, irq_p}, 32'h1);
      done("period");
      wr(ctrl0_addr, 8'h00, axi_okay);
      for (int k = 0; k < 3; k++) begin
         wr(ctrl1_addr, {2'b01, 2'(k), 4'h0}, axi_okay);
         @(posedge mclk);
         cap <= (k == 1);
         wr(ctrl0_addr, 8'h18, axi_okay);
         repeat (5) @(posedge mclk);
         wr(flags_addr, 8'h07, axi_okay);
         @(posedge mclk);
         cap <= (k != 1);
         repeat (5) @(posedge mclk);
         rd(flags_addr, 32'h4, 32'h4, axi_okay);
         wr(ctrl0_addr, 8'h00, axi_okay);
      end
      done("capture");
      wr(ctrl1_addr, 8'hA8, axi_okay);
      wr(ctrl0_addr, 8'h19, axi_okay);
      repeat (20) @(posedge mclk);
      tog = 0;
      repeat (256) begin
         @(posedge mclk);
         tog += int'(pin);
      end
      chk(32'(tog), 32'(2 * int'(v)));
      wr(ctrl0_addr, 8'h00, axi_okay);
      done("pwm");
      repeat (5) @(posedge mclk);
      report_and_stop();
   end
endmodule
`default_nettype wire
